// >>> hw/ffb_fifo.sv
// 1K x 36 fifo: flag generation and bus-matched read side
// assumes write and read requests are synchronous to clk
module ffb_fifo (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     resetn,
	// configuration
	input  wire logic                     fall_through_mode,
	input  wire logic                     bus_match_select,
	input  wire logic                     size_select,
	input  wire logic                     byte_order_select,
	input  wire logic [1:0]               offset_select,
	// port a write and offset programming
	input  wire logic                     wr_en,
	input  wire logic [ffb_pkg::DATA_W-1:0] wr_data,
	input  wire logic                     offset_load,
	input  wire logic [ffb_pkg::ADDR_W-1:0] offset_empty_in,
	input  wire logic [ffb_pkg::ADDR_W-1:0] offset_full_in,
	output logic                          full_or_in_ready_flag,
	output logic                          almost_full_flag_n,
	// port b read
	input  wire logic                     rd_en,
	output logic [ffb_pkg::DATA_W-1:0]    rd_data,
	output logic                          empty_or_out_ready_flag,
	output logic                          almost_empty_flag_n
);
	logic [ffb_pkg::DATA_W-1:0] mem [ffb_pkg::DEPTH];
	logic [ffb_pkg::CNT_W-1:0]  wptr_q, rptr_q;
	logic [ffb_pkg::CNT_W-1:0]  wsync_q [ffb_pkg::SYNC_STAGES];
	logic [ffb_pkg::CNT_W-1:0]  rsync_q [ffb_pkg::SYNC_STAGES];
	logic [ffb_pkg::CNT_W-1:0]  wcount, rcount;
	logic [ffb_pkg::ADDR_W-1:0] ofs_x_q, ofs_y_q;
	logic                       cfg_done_q, big_end_q, par_prog_q;
	logic [ffb_pkg::DATA_W-1:0] hold_q;
	logic [1:0]                 idx_q, last_idx;
	logic                       rem_q, ready_q;
	logic                       do_write, advance, take_hold, take_mem, ready_d;
	logic [ffb_pkg::DATA_W-1:0] mem_word;

	// pick piece k of a long-word for the current size and order
	function automatic logic [ffb_pkg::DATA_W-1:0] piece(
		input logic [ffb_pkg::DATA_W-1:0] w,
		input logic [1:0]                 k,
		input logic                       bm,
		input logic                       sz,
		input logic                       be
	);
		logic [1:0] pos;
		pos = 2'h0;
		if (!bm) begin
			piece = w;
		end else if (!sz) begin
			pos = be ? (2'h1 - k) : k;
			piece = {{ffb_pkg::WORD_W{1'b0}},
				pos[0] ? w[35:18] : w[17:0]};
		end else begin
			pos = be ? (2'h3 - k) : k;
			case (pos)
				2'h0: piece = {27'h0, w[8:0]};
				2'h1: piece = {27'h0, w[17:9]};
				2'h2: piece = {27'h0, w[26:18]};
				default: piece = {27'h0, w[35:27]};
			endcase
		end
	endfunction

	// distance between two free-running pointers, wrap included
	function automatic logic [ffb_pkg::CNT_W-1:0] span(
		input logic [ffb_pkg::CNT_W-1:0] head,
		input logic [ffb_pkg::CNT_W-1:0] tail
	);
		span = head - tail;
	endfunction

	assign last_idx = !bus_match_select ? ffb_pkg::LAST_LONG :
		(size_select ? ffb_pkg::LAST_BYTE : ffb_pkg::LAST_WORD);
	assign wcount   = span(wptr_q, rsync_q[ffb_pkg::SYNC_STAGES-1]);
	assign rcount   = span(wsync_q[ffb_pkg::SYNC_STAGES-1], rptr_q);
	assign mem_word = mem[rptr_q[ffb_pkg::ADDR_W-1:0]];
	// nothing is stored before the configuration is caught, so stray writes cannot land
	assign do_write = wr_en && cfg_done_q && (wcount != ffb_pkg::DEPTH_CNT);

	// fall-through loads unrequested while the output register is vacant
	assign advance   = fall_through_mode ? (!ready_q || rd_en) : rd_en;
	assign take_hold = advance && rem_q;
	assign take_mem  = advance && !rem_q && (rcount != '0);
	assign ready_d   = take_mem || take_hold || (ready_q && !advance);

	// configuration caught on the first edge after reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_done_q <= 1'b0;
			big_end_q  <= 1'b1;
			par_prog_q <= 1'b0;
			ofs_x_q    <= ffb_pkg::OFS_8;
			ofs_y_q    <= ffb_pkg::OFS_8;
		end else if (!cfg_done_q) begin
			cfg_done_q <= 1'b1;
			big_end_q  <= byte_order_select;
			par_prog_q <= (offset_select == ffb_pkg::OFS_SEL_PAR);
			case (offset_select)
				ffb_pkg::OFS_SEL_64: begin
					ofs_x_q <= ffb_pkg::OFS_64;
					ofs_y_q <= ffb_pkg::OFS_64;
				end
				ffb_pkg::OFS_SEL_16: begin
					ofs_x_q <= ffb_pkg::OFS_16;
					ofs_y_q <= ffb_pkg::OFS_16;
				end
				default: begin
					ofs_x_q <= ffb_pkg::OFS_8;
					ofs_y_q <= ffb_pkg::OFS_8;
				end
			endcase
		end else if (par_prog_q && offset_load) begin
			ofs_x_q <= offset_empty_in;
			ofs_y_q <= offset_full_in;
		end
	end

	// write side
	always_ff @(posedge clk) begin
		if (do_write)
			mem[wptr_q[ffb_pkg::ADDR_W-1:0]] <= wr_data;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			wptr_q <= '0;
		else if (do_write)
			wptr_q <= wptr_q + 11'h001;
	end

	// pointer synchronisers; only the last stage is looked at
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < ffb_pkg::SYNC_STAGES; i++) begin
				wsync_q[i] <= '0;
				rsync_q[i] <= '0;
			end
		end else begin
			wsync_q[0] <= wptr_q;
			rsync_q[0] <= rptr_q;
			for (int i = 1; i < ffb_pkg::SYNC_STAGES; i++) begin
				wsync_q[i] <= wsync_q[i-1];
				rsync_q[i] <= rsync_q[i-1];
			end
		end
	end

	// read pointer: a fetch frees the slot the moment it leaves memory
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rptr_q <= '0;
		else if (take_mem)
			rptr_q <= rptr_q + 11'h001;
	end

	// output register and holding register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= '0;
			hold_q  <= '0;
			idx_q   <= 2'h0;
			rem_q   <= 1'b0;
			ready_q <= 1'b0;
		end else if (take_mem) begin
			hold_q  <= mem_word;
			rd_data <= piece(mem_word, 2'h0, bus_match_select, size_select, big_end_q);
			idx_q   <= 2'h0;
			rem_q   <= (last_idx != 2'h0);
			ready_q <= 1'b1;
		end else if (take_hold) begin
			rd_data <= piece(hold_q, idx_q + 2'h1, bus_match_select, size_select,
				big_end_q);
			idx_q   <= idx_q + 2'h1;
			rem_q   <= ((idx_q + 2'h1) != last_idx);
			ready_q <= 1'b1;
		end else if (advance) begin
			ready_q <= 1'b0;
		end
	end

	// flags, registered from the counts seen on each side; empty/out-ready also from the output and holding register state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			empty_or_out_ready_flag <= 1'b0;
			almost_empty_flag_n     <= 1'b0;
		end else begin
			if (fall_through_mode)
				// out-ready follows the output register's next state, never outliving the word
				empty_or_out_ready_flag <= ready_d;
			else
				empty_or_out_ready_flag <= (rcount != '0) || rem_q;
			almost_empty_flag_n <= (rcount > {1'b0, ofs_x_q});
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			full_or_in_ready_flag <= 1'b0;
			almost_full_flag_n    <= 1'b1;
		end else begin
			full_or_in_ready_flag <= cfg_done_q && (wcount != ffb_pkg::DEPTH_CNT);
			almost_full_flag_n    <= (wcount < (ffb_pkg::DEPTH_CNT - {1'b0, ofs_y_q}));
		end
	end
endmodule

// >>> hw/ffb_pkg.sv
// constants for the bus-matching fifo flag and read block
// assumes a single 100 MHz clock; both ports are sampled on it
package ffb_pkg;
	localparam int          DATA_W      = 36;
	localparam int          DEPTH       = 1024;
	localparam int          ADDR_W      = 10;
	localparam int          CNT_W       = 11;
	localparam int          SYNC_STAGES = 2;
	localparam int          BYTE_W      = 9;
	localparam int          WORD_W      = 18;
	// offset selection sampled at reset release
	localparam logic [1:0]  OFS_SEL_64  = 2'h3;
	localparam logic [1:0]  OFS_SEL_16  = 2'h2;
	localparam logic [1:0]  OFS_SEL_8   = 2'h1;
	localparam logic [1:0]  OFS_SEL_PAR = 2'h0;
	localparam logic [ADDR_W-1:0] OFS_64 = 10'h040;
	localparam logic [ADDR_W-1:0] OFS_16 = 10'h010;
	localparam logic [ADDR_W-1:0] OFS_8  = 10'h008;
	localparam logic [CNT_W-1:0]  DEPTH_CNT = 11'h400;
	// pieces per long-word, minus one
	localparam logic [1:0]  LAST_LONG   = 2'h0;
	localparam logic [1:0]  LAST_WORD   = 2'h1;
	localparam logic [1:0]  LAST_BYTE   = 2'h3;
endpackage

// >>> test/ffb_writer.sv
// writer model for the fifo write port: one long-word per cycle while asked
// assumes go and din change just after the rising clock edge
module ffb_writer (
	// clock
	input  wire logic        clk,
	// request from the bench
	input  wire logic        go,
	input  wire logic [35:0] din,
	// fifo write port
	output logic             wr_en = 1'b0,
	output logic [35:0]      wr_data = 36'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle data is inverted so a stale word never passes for a fresh one
	always @(posedge clk) begin
		wr_en <= go;
		wr_data <= go ? din : ~wr_data;
	end
endmodule

// >>> test/ffb_fifo_asserts.sv
// flag and read-lane relations of the fifo
// sees only the fifo ports; attached by the bind below
module ffb_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// configuration
	input wire logic        fall_through_mode,
	input wire logic        bus_match_select,
	input wire logic        size_select,
	// requests
	input wire logic        wr_en,
	input wire logic        rd_en,
	// read data and flags
	input wire logic [35:0] rd_data,
	input wire logic        full_or_in_ready_flag,
	input wire logic        almost_full_flag_n,
	input wire logic        empty_or_out_ready_flag,
	input wire logic        almost_empty_flag_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_full_almost: assert property (
		$fell(full_or_in_ready_flag) |-> !almost_full_flag_n)
		else $error("full without almost full");
	a_empty_almost: assert property (
		!fall_through_mode && !empty_or_out_ready_flag |-> !almost_empty_flag_n)
		else $error("empty without almost empty");
	a_word_lanes: assert property (
		bus_match_select && !size_select |-> rd_data[35:18] == 18'h0)
		else $error("upper lines busy in word mode");
	a_byte_lanes: assert property (
		bus_match_select && size_select |-> rd_data[35:9] == 27'h0)
		else $error("upper lines busy in byte mode");
	a_rd_hold: assert property (
		!fall_through_mode && !rd_en |=> $stable(rd_data))
		else $error("read data moved without a read");
	// the write that fills the last slot is seen two edges before the flag is
	a_full_cause: assert property (
		$fell(full_or_in_ready_flag) |-> $past(wr_en, 2))
		else $error("full flag fell without a write");
	a_empty_lag: assert property (
		(!wr_en)[*4] ##1 (!fall_through_mode && !empty_or_out_ready_flag && wr_en
		&& full_or_in_ready_flag) |=> !empty_or_out_ready_flag ##[1:4] empty_or_out_ready_flag)
		else $error("empty flag crossing timing wrong");
	// a read takes four edges to reach the full flag, so reads in flight are ruled out
	a_full_hold: assert property (
		(!rd_en)[*4] ##1 ($fell(full_or_in_ready_flag) && !rd_en) ##1 (!rd_en)[*3]
		|-> !full_or_in_ready_flag)
		else $error("full released without a read");
	c_full: cover property (!full_or_in_ready_flag);
	c_word: cover property (bus_match_select && !size_select && rd_en);
	c_byte: cover property (bus_match_select && size_select && rd_en);
	c_fall: cover property (fall_through_mode && empty_or_out_ready_flag);
endmodule
bind ffb_fifo ffb_asserts u_chk (.clk, .resetn, .fall_through_mode, .bus_match_select,
	.size_select, .wr_en, .rd_en, .rd_data, .full_or_in_ready_flag, .almost_full_flag_n,
	.empty_or_out_ready_flag, .almost_empty_flag_n);

// >>> test/tb_top.sv
// self-checking bench for the fifo with a writer model on port a
// assumes ffb_writer and the bound checker are compiled alongside
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, resetn, ftm, bmatch, sz, bord, go, ofl, rd_en, wr_en;
	logic        full, afull, empty, aempty;
	logic [1:0]  sel;
	logic [9:0]  ox, oy;
	logic [35:0] din, wd, rd, r;
	logic [35:0] q[$];
	logic [31:0] s = 32'h804E;
	int          fails, tests_run, x;
	ffb_fifo dut (.clk, .resetn, .fall_through_mode(ftm), .bus_match_select(bmatch),
		.size_select(sz), .byte_order_select(bord), .offset_select(sel), .wr_en,
		.wr_data(wd), .offset_load(ofl), .offset_empty_in(ox), .offset_full_in(oy),
		.full_or_in_ready_flag(full), .almost_full_flag_n(afull), .rd_en, .rd_data(rd),
		.empty_or_out_ready_flag(empty), .almost_empty_flag_n(aempty));
	ffb_writer wrm (.clk, .go, .din, .wr_en, .wr_data(wd));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	function logic [35:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return {s[7:4], s};
	endfunction
	function logic [35:0] piece(logic [35:0] w, int i);
		if (!bmatch)
			return w;
		if (!sz)
			return {18'h0, (bord ^ (i == 1)) ? w[35:18] : w[17:0]};
		return {27'h0, w[9 * (bord ? 3 - i : i) +: 9]};
	endfunction
	task chk(logic [35:0] got, logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude();
		$display("checks=%0d mismatches=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// flags cross in three to four cycles, so eight always settles
	task wt();
		repeat (8) @(posedge clk);
		#1;
	endtask
	task setup(logic f, logic m, logic z, logic b, logic [1:0] o);
		@(posedge clk);
		resetn <= 0;
		{ftm, bmatch, sz, bord, sel} <= {f, m, z, b, o};
		q.delete();
		repeat (20) @(posedge clk);
		resetn <= 1;
		wt();
	endtask
	task put(int n);
		repeat (n) begin
			@(posedge clk);
			go <= 1;
			din <= rnd();
			#1 q.push_back(din);
		end
		@(posedge clk);
		go <= 0;
		wt();
	endtask
	task get();
		logic [35:0] w;
		while (q.size() > 0) begin
			w = q.pop_front();
			for (int i = 0; i < (bmatch ? (sz ? 4 : 2) : 1); i++) begin
				@(posedge clk);
				rd_en <= 1;
				@(posedge clk);
				rd_en <= 0;
				#1 chk(rd, piece(w, i));
			end
		end
		wt();
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		{resetn, ftm, bmatch, sz, bord, sel, go, ofl, rd_en, ox, oy, din} = '0;
		// every size and byte order; the first pass takes offset 64, the last programs its own
		for (int c = 0; c < 6; c++) begin
			setup(0, c > 0, c > 2, c[0], (c == 5) ? 2'h0 : ((c == 0) ? 2'h3 : 2'h1));
			x = (c == 0) ? 64 : 8;
			if (c == 5) begin
				r = rnd();
				@(posedge clk);
				ox <= {6'h0, r[3:0]} + 10'h1;
				oy <= {6'h0, r[7:4]};
				ofl <= 1;
				@(posedge clk);
				ofl <= 0;
				x = r[3:0] + 1;
			end
			chk(empty, 1'b0);
			put(x);
			chk(aempty, 1'b0);
			put(1);
			chk(aempty, 1'b1);
			chk(empty, 1'b1);
			get();
			chk(empty, 1'b0);
		end
		setup(0, 0, 0, 1, 2'h2);
		put(1007);
		chk(afull, 1'b1);
		put(1);
		chk(afull, 1'b0);
		put(16);
		chk(full, 1'b0);
		put(1);
		void'(q.pop_back());
		get();
		chk(full, 1'b1);
		setup(1, 0, 0, 1, 2'h1);
		put(1);
		chk(rd, q[0]);
		chk(empty, 1'b1);
		chk(aempty, 1'b0);
		put(1024);
		chk(full, 1'b0);
		conclude();
	end
endmodule
